// *** core/dwr_pkg.sv ***
// package for the default wake-ready controller
// assumes one 200 MHz clock and an asynchronous active-low reset
package dwr_pkg;
   localparam real PULSE_TIME_MS = 1.363;
   localparam real CLK_MHZ = 200.0;
   // active pulse is a least time: round up
   localparam int PULSE_CYCLES_INT = int'($ceil(PULSE_TIME_MS * 1000.0 * CLK_MHZ));
   localparam logic [18:0] PULSE_CYCLES = PULSE_CYCLES_INT[18:0];

   // configuration flag word field positions
   localparam int FLAG_SELF_POWER_BIT = 0;
   localparam int FLAG_PIN_ROLE_BIT = 12;
   localparam int FLAG_POLARITY_BIT = 13;
   localparam int FLAG_DRIVE_BIT = 14;
   localparam int FLAG_PULSE_BIT = 15;
   localparam logic [15:0] FLAG_RESET_VALUE = 16'h7001;

   // register offsets of the plain register port
   localparam logic [3:0] REG_CONFIG = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h1;
   localparam logic [3:0] REG_IRQ_STAT = 4'h2;
   localparam logic [3:0] REG_IRQ_MASK = 4'h3;
   localparam logic [2:0] IRQ_RESET_VALUE = 3'h0;
   localparam logic [2:0] MASK_RESET_VALUE = 3'h0;

   typedef enum logic [1:0] {
      DWR_ST_RESET = 2'b00,
      DWR_ST_WAKE_READY = 2'b01,
      DWR_ST_NORMAL = 2'b10
   } dwr_state_t;

   typedef struct packed {
      logic pulse_indication_sel;
      logic output_drive_type;
      logic output_polarity;
      logic pin_role_select;
   } dwr_pin_cfg_t;

   typedef struct packed {
      logic usb_phy_en;
      logic usb_dp_dm_oe;
      logic wake_detect_en;
      logic eth_phy_en;
      logic autoneg_en;
      logic start_enum;
   } dwr_power_ctl_t;
endpackage

// *** core/dwr_sync.sv ***
// two-flop synchroniser for one pin level
// assumes the pin is asynchronous to clk
`timescale 1ns/1ps
module dwr_sync
   import dwr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic din,
   output logic dout
);
   logic meta_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= 1'b1;
         dout <= 1'b1;
      end else begin
         meta_r <= din;
         dout <= meta_r;
      end
   end
endmodule // dwr_sync

// *** core/dwr_pin_drive.sv ***
// power-event pin driver: pulse timer, polarity, drive type
// assumes assert_req is a one-cycle pulse from the controller
`timescale 1ns/1ps
module dwr_pin_drive
   import dwr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire dwr_pin_cfg_t cfg,
   input wire logic assert_req,
   output logic active,
   output logic pin_out,
   output logic pin_oe
);
   logic level_r;
   logic [18:0] cnt_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         level_r <= 1'b0;
         cnt_r <= 19'h0;
      end else if (assert_req && cfg.pin_role_select) begin
         level_r <= 1'b1;
         cnt_r <= PULSE_CYCLES;
      end else if (cfg.pulse_indication_sel && level_r) begin
         // pulse form ends on its own timer
         if (cnt_r <= 19'h1) begin
            level_r <= 1'b0;
            cnt_r <= 19'h0;
         end else begin
            cnt_r <= cnt_r - 19'h1;
         end
      end
      // static form holds until reset
   end

   assign active = level_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_out <= 1'b0;
         pin_oe <= 1'b0;
      end else if (!cfg.pin_role_select) begin
         pin_out <= 1'b0;
         pin_oe <= 1'b0;
      end else if (cfg.output_drive_type) begin
         pin_out <= level_r ~^ cfg.output_polarity;
         pin_oe <= 1'b1;
      end else begin
         // open drain only ever pulls low
         pin_out <= 1'b0;
         pin_oe <= (level_r ~^ cfg.output_polarity) == 1'b0;
      end
   end
endmodule // dwr_pin_drive

// *** core/dwr_ctrl.sv ***
// default wake-ready controller: strap, wake sources, power gating,
// power-event pin, register port with interrupt
// assumes the wake pattern detector gives a one-cycle pulse on clk
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
// Function
// - wake-ready setup comes from config flags and strap, no software needed.
// - in wake-ready, USB off; pattern detector, ethernet PHY, autoneg on.
// - valid wake pattern in wake-ready asserts the power-event output.
// - low on external wake input also asserts the power-event output; the code acts only on a falling edge seen while in wake-ready.
// - after assertion leave wake-ready and start USB enumeration.
// - static level output holds until hardware reset.
// - strap sampled after reset: high enters wake-ready, low normal; the code also needs the pin role and self power flags set for wake-ready.
// - power-event output active high when wake-ready enabled.
// - USB data pins are high impedance during wake-ready.
// - pulse flag 1 gives 1.363 ms pulse, 0 static level.
// - polarity flag 1 active high, 0 active low.
// - drive flag 1 push-pull, 0 open drain.
module dwr_ctrl
   import dwr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wake_strap,
   input wire logic ext_wake_input_n,
   input wire logic wake_pattern_valid,
   input wire logic vbus_sense,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   output logic irq,
   output logic power_event_out,
   output logic power_event_oe,
   output dwr_power_ctl_t power_ctl
);

   ////////////////////////////////////////////////////////////////////
   // pin inputs through two flops
   logic strap_s;
   logic wake_n_s;
   logic vbus_s;
   logic wake_n_d_r;

   dwr_sync u_sync_strap (
      .clk(clk),
      .rst_n(rst_n),
      .din(wake_strap),
      .dout(strap_s)
   );

   dwr_sync u_sync_wake (
      .clk(clk),
      .rst_n(rst_n),
      .din(ext_wake_input_n),
      .dout(wake_n_s)
   );

   dwr_sync u_sync_vbus (
      .clk(clk),
      .rst_n(rst_n),
      .din(vbus_sense),
      .dout(vbus_s)
   );

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_n_d_r <= 1'b1;
      end else begin
         wake_n_d_r <= wake_n_s;
      end
   end

   // falling edge on the synchronised wake input
   logic ext_wake_evt;
   assign ext_wake_evt = wake_n_d_r && !wake_n_s;

   ////////////////////////////////////////////////////////////////////
   // configuration flags, loaded by the configuration source
   logic [15:0] flag_r;
   dwr_pin_cfg_t pin_cfg;
   logic self_powered;
   logic mode_allowed;

   assign pin_cfg.pulse_indication_sel = flag_r[FLAG_PULSE_BIT];
   assign pin_cfg.output_drive_type = flag_r[FLAG_DRIVE_BIT];
   assign pin_cfg.output_polarity = flag_r[FLAG_POLARITY_BIT];
   assign pin_cfg.pin_role_select = flag_r[FLAG_PIN_ROLE_BIT];
   assign self_powered = flag_r[FLAG_SELF_POWER_BIT];
   // mode needs pin role and self power from config
   assign mode_allowed = pin_cfg.pin_role_select && self_powered;

   ////////////////////////////////////////////////////////////////////
   // state machine: strap caught after release, not in reset
   dwr_state_t state_r;
   dwr_state_t state_nxt;
   logic wake_ready_r;
   logic [1:0] settle_r;
   logic wake_evt;
   logic assert_req;

   // both sources count only while in wake-ready
   assign wake_evt = wake_ready_r && (wake_pattern_valid || ext_wake_evt);
   assign assert_req = (state_r == DWR_ST_WAKE_READY) && wake_evt;

   // wait for the synchroniser to carry the real strap level
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         settle_r <= 2'h0;
      end else if (settle_r != 2'h3) begin
         settle_r <= settle_r + 2'h1;
      end
   end

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         DWR_ST_RESET: begin
            if (settle_r == 2'h3) begin
               // strap high enters wake-ready only when the mode is allowed
               if (strap_s && mode_allowed) begin
                  state_nxt = DWR_ST_WAKE_READY;
               end else begin
                  state_nxt = DWR_ST_NORMAL;
               end
            end
         end
         DWR_ST_WAKE_READY: begin
            if (assert_req) begin
               state_nxt = DWR_ST_NORMAL;
            end
         end
         DWR_ST_NORMAL: begin
            state_nxt = DWR_ST_NORMAL;
         end
         default: begin
            state_nxt = DWR_ST_RESET;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= DWR_ST_RESET;
      end else begin
         state_r <= state_nxt;
      end
   end

   // single wake-ready flag
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_ready_r <= 1'b0;
      end else if (state_r == DWR_ST_RESET && state_nxt == DWR_ST_WAKE_READY) begin
         wake_ready_r <= 1'b1;
      end else if (assert_req) begin
         wake_ready_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // power gating of the rest of the device
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         power_ctl <= '0;
      end else begin
         power_ctl.usb_phy_en <= (state_nxt == DWR_ST_NORMAL);
         power_ctl.usb_dp_dm_oe <= (state_nxt == DWR_ST_NORMAL);
         power_ctl.wake_detect_en <= (state_nxt == DWR_ST_WAKE_READY);
         power_ctl.eth_phy_en <= (state_nxt != DWR_ST_RESET);
         power_ctl.autoneg_en <= (state_nxt != DWR_ST_RESET);
         // enumeration starts at once in normal mode
         power_ctl.start_enum <= (state_nxt == DWR_ST_NORMAL);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // power-event pin
   logic pe_active;

   dwr_pin_drive u_pin (
      .clk(clk),
      .rst_n(rst_n),
      .cfg(pin_cfg),
      .assert_req(assert_req),
      .active(pe_active),
      .pin_out(power_event_out),
      .pin_oe(power_event_oe)
   );

   ////////////////////////////////////////////////////////////////////
   // register port
   logic [2:0] irq_stat_r;
   logic [2:0] irq_mask_r;
   logic [2:0] irq_evt;
   logic stat_rd;

   // pattern wake, external wake, power event asserted
   assign irq_evt = {assert_req, ext_wake_evt, wake_pattern_valid && wake_ready_r};
   assign stat_rd = reg_rd && (reg_addr == REG_IRQ_STAT);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_r <= FLAG_RESET_VALUE;
      end else if (reg_wr && reg_addr == REG_CONFIG) begin
         // changing flags after the strap decision affects only the pin
         flag_r <= reg_wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_mask_r <= MASK_RESET_VALUE;
      end else if (reg_wr && reg_addr == REG_IRQ_MASK) begin
         irq_mask_r <= reg_wdata[2:0];
      end
   end

   // a new event wins over the clear by read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_r <= IRQ_RESET_VALUE;
      end else begin
         irq_stat_r <= (stat_rd ? 3'h0 : irq_stat_r) | irq_evt;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((stat_rd ? 3'h0 : irq_stat_r) | irq_evt) & irq_mask_r);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 16'h0;
      end else if (reg_rd) begin
         case (reg_addr)
            REG_CONFIG: reg_rdata <= flag_r;
            REG_STATUS: reg_rdata <= {10'h0, vbus_s, pe_active, wake_ready_r,
                                      strap_s, state_r};
            REG_IRQ_STAT: reg_rdata <= {13'h0, irq_stat_r};
            REG_IRQ_MASK: reg_rdata <= {13'h0, irq_mask_r};
            default: reg_rdata <= 16'h0;
         endcase
      end else begin
         reg_rdata <= 16'h0;
      end
   end

endmodule // dwr_ctrl

// *** tb/dwr_ctrl_chk.sv ***
// port checker for the wake-ready controller
// assumes one clock domain, bound to every dwr_ctrl instance
`timescale 1ns/1ps
module dwr_ctrl_chk
   import dwr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wake_strap,
   input wire logic ext_wake_input_n,
   input wire logic wake_pattern_valid,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic power_event_out,
   input wire logic power_event_oe,
   input wire dwr_power_ctl_t power_ctl
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [3:0] cnt_r;
   logic pulse_r;
   wire ready = power_ctl.autoneg_en && !power_ctl.start_enum;
   wire [1:0] pin = {power_event_out, power_event_oe};
   // pulse mode ends the level on its own, so the hold check skips it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 4'h0;
         pulse_r <= FLAG_RESET_VALUE[FLAG_PULSE_BIT];
      end else begin
         if (cnt_r != 4'hf) cnt_r <= cnt_r + 4'h1;
         if (reg_wr && reg_addr == REG_CONFIG) pulse_r <= reg_wdata[FLAG_PULSE_BIT];
      end
   end
   a_usb_pins_off: assert property (!power_ctl.start_enum |-> !power_ctl.usb_dp_dm_oe)
      else $error("usb pins driven before enumeration");
   a_ready_blocks: assert property (ready |-> power_ctl.wake_detect_en &&
      power_ctl.eth_phy_en && !power_ctl.usb_phy_en)
      else $error("wake-ready power gating wrong");
   a_pattern_wakes: assert property (ready && wake_pattern_valid |=>
      power_ctl.start_enum ##1 !$stable(pin))
      else $error("pattern wake not taken");
   a_ext_wakes: assert property (ready && $fell(ext_wake_input_n) |->
      ##[1:5] power_ctl.start_enum)
      else $error("external wake not taken");
   a_enum_sticks: assert property (power_ctl.start_enum |=> power_ctl.start_enum)
      else $error("left normal operation");
   a_pin_holds: assert property (power_ctl.start_enum && $past(power_ctl.start_enum, 2) &&
      !pulse_r && !$past(reg_wr) && !$past(reg_wr, 2) |-> $stable(pin))
      else $error("static pin level moved");
   a_strap_low: assert property (cnt_r == 4'h6 && !wake_strap |-> power_ctl.start_enum)
      else $error("strap low did not enumerate");
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data outside its cycle");
   a_unmapped_zero: assert property (reg_rd && reg_addr > REG_IRQ_MASK |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
endmodule // dwr_ctrl_chk

bind dwr_ctrl dwr_ctrl_chk dwr_ctrl_chk_i (.clk(clk), .rst_n(rst_n), .wake_strap(wake_strap),
   .ext_wake_input_n(ext_wake_input_n), .wake_pattern_valid(wake_pattern_valid),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .power_event_out(power_event_out),
   .power_event_oe(power_event_oe), .power_ctl(power_ctl));

// *** tb/dwr_power_controller_ic_model.sv ***
// power controller model on the power-event pin
// assumes a pull-down on the pin net
`timescale 1ns/1ps
module dwr_power_controller_ic_model
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin_out,
   input wire logic pin_oe,
   output logic vbus_sense
);
   logic [3:0] ramp_r;
   // released net falls to the pull-down level
   wire line = pin_oe ? pin_out : 1'b0;
   // high level switches the supply on, sense rises after a ramp
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ramp_r <= 4'h0;
      end else if (line && ramp_r != 4'h8) begin
         ramp_r <= ramp_r + 4'h1;
      end
   end
   assign vbus_sense = (ramp_r == 4'h8);
endmodule // dwr_power_controller_ic_model

// *** tb/tb.sv ***
// self-checking bench for the wake-ready controller
// assumes reset flag word from the package and a power controller model
`timescale 1ns/1ps
module tb;
   import dwr_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic wake_strap = 1'b1;
   logic ext_n = 1'b1;
   logic pat = 1'b0;
   logic vbus;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [15:0] rdata;
   logic irq;
   logic pe_out;
   logic pe_oe;
   dwr_power_ctl_t pctl;
   int errors = 0;
   int samples_checked = 0;
   logic [31:0] seed = 32'hd408;
   always #2.5 clk = ~clk;
   dwr_ctrl dwr_ctrl_i (.clk(clk), .rst_n(rst_n), .wake_strap(wake_strap),
      .ext_wake_input_n(ext_n), .wake_pattern_valid(pat), .vbus_sense(vbus),
      .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
      .irq(irq), .power_event_out(pe_out), .power_event_oe(pe_oe), .power_ctl(pctl));
   dwr_power_controller_ic_model dwr_power_controller_ic_model_i (.clk(clk), .rst_n(rst_n), .pin_out(pe_out),
      .pin_oe(pe_oe), .vbus_sense(vbus));
   ////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // open drain only ever pulls low
   function automatic logic [15:0] pin_exp(input logic pol, input logic drv, input logic act);
      logic lvl;
      lvl = act ? pol : ~pol;
      return drv ? {14'h0, lvl, 1'b1} : {14'h0, 1'b0, ~lvl};
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rd_reg(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check(rdata & m, e);
   endtask
   task automatic do_reset(input logic strap);
      rst_n <= 1'b0;
      wake_strap <= strap;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      #1;
   endtask
   // fire one wake source, wait bounded for enumeration to start
   task automatic fire(input logic ext);
      int i;
      if (ext) ext_n <= 1'b0;
      else pat <= 1'b1;
      @(posedge clk);
      pat <= 1'b0;
      #1;
      i = 0;
      while (pctl.start_enum !== 1'b1 && i < 8) begin
         @(posedge clk);
         #1;
         i++;
      end
   endtask
   initial begin
      #100000;
      errors++;
      print_verdict();
   end
   initial begin
      logic pol;
      logic drv;
      logic src;
      logic [2:0] m;
      logic [2:0] st;
      for (int k = 3; k >= 0; k--) begin
         pol = k[0];
         drv = k[1];
         seed = xs(seed);
         src = seed[0];
         m = seed[3:1];
         do_reset(1'b1);
         check({10'h0, pctl}, 16'h000e);
         rd_reg(REG_STATUS, 16'h000f, 16'h000d);
         rd_reg(REG_CONFIG, 16'hffff, FLAG_RESET_VALUE);
         wr_reg(REG_CONFIG, {1'b0, drv, pol, 13'h1001});
         wr_reg(REG_IRQ_MASK, {13'h0, m});
         check({14'h0, pe_out, pe_oe}, pin_exp(pol, drv, 1'b0));
         fire(src);
         @(posedge clk);
         #1;
         check({14'h0, pe_out, pe_oe}, pin_exp(pol, drv, 1'b1));
         check({14'h0, pctl.usb_phy_en, pctl.start_enum}, 16'h0003);
         ext_n <= 1'b1;
         st = src ? 3'h6 : 3'h5;
         repeat (2) @(posedge clk);
         #1;
         check({15'h0, irq}, {15'h0, |(st & m)});
         rd_reg(REG_IRQ_STAT, 16'h0007, {13'h0, st});
         @(posedge clk);
         #1;
         check({15'h0, irq}, 16'h0000);
         repeat (40 + seed[11:4]) @(posedge clk);
         pat <= 1'b1;
         @(posedge clk);
         pat <= 1'b0;
         repeat (3) @(posedge clk);
         #1;
         check({14'h0, pe_out, pe_oe}, pin_exp(pol, drv, 1'b1));
         if (k == 3) rd_reg(REG_STATUS, 16'h003f, 16'h0036);
         $display("wake test pol=%0d drive=%0d src=%0d done", pol, drv, src);
      end
      do_reset(1'b0);
      rd_reg(REG_STATUS, 16'h000f, 16'h0002);
      check({15'h0, pctl.start_enum}, 16'h0001);
      fire(1'b0);
      repeat (3) @(posedge clk);
      #1;
      check({14'h0, pe_out, pe_oe}, pin_exp(1'b1, 1'b1, 1'b0));
      rd_reg(4'h9, 16'hffff, 16'h0000);
      // pin role off: the pin is released, not driven
      wr_reg(REG_CONFIG, 16'h6001);
      @(posedge clk);
      #1;
      check({14'h0, pe_out, pe_oe}, 16'h0000);
      $display("strap low test done");
      print_verdict();
   end
endmodule // tb
